// ==== logic/epm_pkg.sv ====
// constants and types for the exception priority map
package epm_pkg;
  // vector positions
  localparam int VN = 48;
  localparam logic [5:0] V_SP     = 6'h00;
  localparam logic [5:0] V_RESET  = 6'h01;
  localparam logic [5:0] V_NMI    = 6'h02;
  localparam logic [5:0] V_HARD   = 6'h03;
  localparam logic [5:0] V_MEM    = 6'h04;
  localparam logic [5:0] V_BUS    = 6'h05;
  localparam logic [5:0] V_USAGE  = 6'h06;
  localparam logic [5:0] V_SVC    = 6'h0b;
  localparam logic [5:0] V_DBG    = 6'h0c;
  localparam logic [5:0] V_PENDABLE_SERVICE_REQUEST = 6'h0e;
  localparam logic [5:0] V_TICK   = 6'h0f;
  localparam int         V_IRQ0   = 16;
  // ranks, lower is more urgent
  localparam logic [3:0] RK_RESET = 4'h0;
  localparam logic [3:0] RK_NMI   = 4'h1;
  localparam logic [3:0] RK_HARD  = 4'h2;
  localparam logic [3:0] RK_SET0  = 4'h3;
  localparam logic [3:0] RK_BASE  = 4'hb;
  localparam logic [2:0] PRI_RST  = 3'h0;
  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_IRQ_EN = 8'h04;
  localparam logic [7:0] OFF_PRI_SY = 8'h08;
  localparam logic [7:0] OFF_PRI_IR = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_PEND   = 8'h20;
  // ctrl bits and field layout
  localparam int CB_NMI    = 0;
  localparam int CB_PENDABLE_SERVICE_REQUEST = 1;
  localparam int CB_BUS_EN = 2;
  localparam int CB_DBG_EN = 3;
  localparam int PF_W      = 4;
  localparam int PF_PER    = 8;
  localparam logic [31:0] IRQ_MASK = 32'h3ffc01ff;
  localparam logic [6:0][5:0] SYS_VEC =
    {V_TICK, V_PENDABLE_SERVICE_REQUEST, V_DBG, V_SVC, V_USAGE, V_BUS, V_MEM};

  typedef enum logic [1:0] {ST_SP, ST_RESET, ST_RUN} epm_st_t;
  typedef logic [VN-1:0][2:0] epm_pri_t;

  typedef struct packed {
    logic first_insn;
    logic mem_fault;
    logic bus_fault;
    logic usage_fault;
    logic svc_exec;
    logic dbg_req;
    logic halting;
    logic tick_expire;
    logic ack;
    logic ret;
  } epm_core_ev_t;

  typedef struct packed {
    epm_st_t     st;
    logic        sp_load;
    logic [31:0] irq_s1;
    logic [31:0] irq_s2;
    logic [VN-1:0] pend;
    logic [3:0]  act_rank;
    logic [5:0]  act_vec;
    logic        bus_en;
    logic        dbg_en;
    logic [31:0] irq_en;
    epm_pri_t    pri;
    logic        out_valid;
    logic [5:0]  out_vec;
    logic [3:0]  out_rank;
    logic [31:0] prdata;
  } epm_state_t;

  localparam epm_state_t STATE_RST = '{
    st: ST_SP, sp_load: 1'b1, act_rank: RK_RESET, act_vec: V_RESET,
    out_vec: V_SP, default: '0};
endpackage

// ==== logic/epm_exception_map.sv ====
// exception priority map with apb register slave
// Functional notes
// [RQ1] reset first loads stack top, vector 0
// [RQ2] reset is vector 1, rank highest
// [RQ3] first instruction drops reset to base level
// [RQ4] nmi vector 2, preempted only by reset
// [RQ5] nmi raised only by software write
// [RQ6] blocked configurable faults escalate to hard fault
// [RQ7] memory management fault vector 4, settable
// [RQ8] bus fault vector 5, settable priority
// [RQ9] software enables or disables bus fault
// [RQ10] usage fault vector 6, settable priority
// [RQ11] service call vector 11 on supervisor call
// [RQ12] debug monitor gated by enable, halt, priority
// [RQ13] pendable service vector 14, software only
// [RQ14] system tick vector 15 on expiry
// [RQ15] interrupt lines map to vector 16 up
// [RQ16] settable priorities reset to zero
// [RQ17] fixed peripheral to line assignment
// [RQ18] eight levels, seven handlers, 21 lines
// [RQ19] equal priority: lower position wins
// [RQ20] settable level 0 ranks fourth overall
// [RQ21] reserved lines never raised
// [RQ22] lower value wins, winner shown to core
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module epm_exception_map (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 SYS_RST,
  // apb slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // core events and peripheral lines
  input  wire epm_pkg::epm_core_ev_t CORE_EV,
  input  wire logic [31:0]          IRQ,
  // to core
  output logic                      SP_LOAD,
  output logic                      VEC_VALID,
  output logic      [5:0]           VEC_NUM,
  output logic      [3:0]           VEC_RANK,
  output logic      [5:0]           ACT_VEC,
  output logic      [3:0]           ACT_RANK
);
  epm_pkg::epm_state_t q;
  epm_pkg::epm_state_t nxt;
  logic [3:0]          best_r;
  logic [5:0]          best_v;
  logic                wr;
  logic                rd_setup;
  logic                mapped;
  logic [3:0]          rk_mem;
  logic [3:0]          rk_bus;
  logic [3:0]          rk_usage;
  logic [3:0]          rk_dbg;

  function automatic logic [3:0] rank_of(input int v,
                                         input epm_pkg::epm_pri_t p);
    logic [3:0] r;
    if (v == int'(epm_pkg::V_RESET))
      r = epm_pkg::RK_RESET; // RQ2
    else if (v == int'(epm_pkg::V_NMI))
      r = epm_pkg::RK_NMI; // RQ4
    else if (v == int'(epm_pkg::V_HARD))
      r = epm_pkg::RK_HARD; // RQ6
    else
      r = epm_pkg::RK_SET0 + {1'b0, p[v]}; // RQ20
    return r;
  endfunction

  assign wr       = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE;
  assign mapped   = (PADDR == epm_pkg::OFF_CTRL) ||
                    (PADDR == epm_pkg::OFF_IRQ_EN) ||
                    (PADDR == epm_pkg::OFF_PRI_SY) ||
                    (PADDR >= epm_pkg::OFF_PRI_IR &&
                     PADDR < epm_pkg::OFF_STATUS &&
                     PADDR[1:0] == 2'h0) ||
                    (PADDR == epm_pkg::OFF_STATUS) ||
                    (PADDR == epm_pkg::OFF_PEND);
  assign rk_mem   = rank_of(int'(epm_pkg::V_MEM), q.pri);
  assign rk_bus   = rank_of(int'(epm_pkg::V_BUS), q.pri);
  assign rk_usage = rank_of(int'(epm_pkg::V_USAGE), q.pri);
  assign rk_dbg   = rank_of(int'(epm_pkg::V_DBG), q.pri);

  always_comb begin
    nxt         = q;
    best_r      = epm_pkg::RK_BASE;
    best_v      = epm_pkg::V_SP;
    nxt.irq_s1  = IRQ;
    nxt.irq_s2  = q.irq_s1;
    nxt.sp_load = 1'b0;
    // reset sequence and core handshake
    unique case (q.st)
      epm_pkg::ST_SP: begin
        nxt.st = epm_pkg::ST_RESET; // RQ1
      end
      epm_pkg::ST_RESET: begin
        if (CORE_EV.first_insn) begin
          nxt.st       = epm_pkg::ST_RUN; // RQ3
          nxt.act_rank = epm_pkg::RK_BASE; // RQ3
          nxt.act_vec  = epm_pkg::V_SP;
        end
      end
      epm_pkg::ST_RUN: begin
        if (CORE_EV.ack && q.out_valid) begin
          nxt.pend[q.out_vec] = 1'b0;
          nxt.act_rank        = q.out_rank; // RQ22
          nxt.act_vec         = q.out_vec;
        end else if (CORE_EV.ret) begin
          nxt.act_rank = epm_pkg::RK_BASE;
          nxt.act_vec  = epm_pkg::V_SP;
        end
      end
    endcase
    // register writes
    if (wr && PADDR == epm_pkg::OFF_CTRL) begin
      nxt.bus_en = PWDATA[epm_pkg::CB_BUS_EN]; // RQ9
      nxt.dbg_en = PWDATA[epm_pkg::CB_DBG_EN];
    end
    if (wr && PADDR == epm_pkg::OFF_IRQ_EN)
      nxt.irq_en = PWDATA & epm_pkg::IRQ_MASK; // RQ21
    for (int k = 0; k < 7; k++) begin
      if (wr && PADDR == epm_pkg::OFF_PRI_SY)
        nxt.pri[epm_pkg::SYS_VEC[k]] = PWDATA[k*epm_pkg::PF_W +: 3]; // RQ18
    end
    for (int i = 0; i < 32; i++) begin
      if (wr && epm_pkg::IRQ_MASK[i] &&
          PADDR == epm_pkg::OFF_PRI_IR + 8'((i / epm_pkg::PF_PER) * 4))
        nxt.pri[epm_pkg::V_IRQ0 + i] =
          PWDATA[(i % epm_pkg::PF_PER) * epm_pkg::PF_W +: 3]; // RQ18
    end
    // event sources, set after clear so set wins
    if (q.st == epm_pkg::ST_RUN) begin
      if (wr && PADDR == epm_pkg::OFF_CTRL && PWDATA[epm_pkg::CB_NMI])
        nxt.pend[epm_pkg::V_NMI] = 1'b1; // RQ5
      if (wr && PADDR == epm_pkg::OFF_CTRL && PWDATA[epm_pkg::CB_PENDABLE_SERVICE_REQUEST])
        nxt.pend[epm_pkg::V_PENDABLE_SERVICE_REQUEST] = 1'b1; // RQ13
      if (CORE_EV.mem_fault) begin
        if (rk_mem < q.act_rank)
          nxt.pend[epm_pkg::V_MEM] = 1'b1; // RQ7
        else
          nxt.pend[epm_pkg::V_HARD] = 1'b1; // RQ6
      end
      if (CORE_EV.bus_fault) begin
        if (q.bus_en && rk_bus < q.act_rank)
          nxt.pend[epm_pkg::V_BUS] = 1'b1; // RQ8
        else
          nxt.pend[epm_pkg::V_HARD] = 1'b1; // RQ6
      end
      if (CORE_EV.usage_fault) begin
        if (rk_usage < q.act_rank)
          nxt.pend[epm_pkg::V_USAGE] = 1'b1; // RQ10
        else
          nxt.pend[epm_pkg::V_HARD] = 1'b1; // RQ6
      end
      if (CORE_EV.svc_exec)
        nxt.pend[epm_pkg::V_SVC] = 1'b1; // RQ11
      if (CORE_EV.dbg_req && q.dbg_en && !CORE_EV.halting &&
          rk_dbg < q.act_rank)
        nxt.pend[epm_pkg::V_DBG] = 1'b1; // RQ12
      if (CORE_EV.tick_expire)
        nxt.pend[epm_pkg::V_TICK] = 1'b1; // RQ14
      for (int i = 0; i < 32; i++) begin
        if (q.irq_s2[i] && q.irq_en[i] && epm_pkg::IRQ_MASK[i])
          nxt.pend[epm_pkg::V_IRQ0 + i] = 1'b1; // RQ15 RQ17
      end
    end
    // arbitration, ascending scan keeps lower position on ties
    for (int v = 2; v < epm_pkg::VN; v++) begin
      if (nxt.pend[v] && rank_of(v, nxt.pri) < best_r) begin
        best_r = rank_of(v, nxt.pri); // RQ22
        best_v = 6'(v); // RQ19
      end
    end
    if (nxt.st == epm_pkg::ST_RUN) begin
      nxt.out_valid = best_r < nxt.act_rank; // RQ22 RQ4
      nxt.out_vec   = best_v;
      nxt.out_rank  = best_r;
    end else begin
      nxt.out_valid = nxt.st == epm_pkg::ST_RESET; // RQ2
      nxt.out_vec   = (nxt.st == epm_pkg::ST_SP) ? epm_pkg::V_SP
                                                  : epm_pkg::V_RESET;
      nxt.out_rank  = epm_pkg::RK_RESET;
    end
    // read data captured in setup phase
    if (rd_setup) begin
      unique case (PADDR)
        epm_pkg::OFF_CTRL: begin
          nxt.prdata                     = 32'h0;
          nxt.prdata[epm_pkg::CB_BUS_EN] = q.bus_en;
          nxt.prdata[epm_pkg::CB_DBG_EN] = q.dbg_en;
        end
        epm_pkg::OFF_IRQ_EN:
          nxt.prdata = q.irq_en;
        epm_pkg::OFF_PRI_SY: begin
          nxt.prdata = 32'h0;
          for (int k = 0; k < 7; k++)
            nxt.prdata[k*epm_pkg::PF_W +: 3] = q.pri[epm_pkg::SYS_VEC[k]];
        end
        epm_pkg::OFF_STATUS:
          nxt.prdata = {8'h0, q.st, q.act_rank, q.act_vec,
                        q.out_rank, q.out_valid, 1'b0, q.out_vec};
        epm_pkg::OFF_PEND:
          nxt.prdata = q.pend[epm_pkg::VN-1:epm_pkg::V_IRQ0];
        default: begin
          nxt.prdata = 32'h0;
          for (int i = 0; i < 32; i++) begin
            if (PADDR == epm_pkg::OFF_PRI_IR + 8'((i / epm_pkg::PF_PER) * 4))
              nxt.prdata[(i % epm_pkg::PF_PER) * epm_pkg::PF_W +: 3] =
                q.pri[epm_pkg::V_IRQ0 + i];
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST)
      q <= epm_pkg::STATE_RST; // RQ1 RQ2 RQ16
    else
      q <= nxt;
  end

  assign PRDATA    = q.prdata;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !mapped;
  assign SP_LOAD   = q.sp_load;
  assign VEC_VALID = q.out_valid;
  assign VEC_NUM   = q.out_vec;
  assign VEC_RANK  = q.out_rank;
  assign ACT_VEC   = q.act_vec;
  assign ACT_RANK  = q.act_rank;

  a_sp_then_reset: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ1
    q.st == epm_pkg::ST_SP && !SYS_RST |-> SP_LOAD && VEC_NUM == epm_pkg::V_SP
      ##1 !SP_LOAD && VEC_VALID && VEC_NUM == epm_pkg::V_RESET)
    else $error("stack load not followed by reset vector");
  a_reset_top: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ2
    q.st == epm_pkg::ST_RESET |-> ACT_RANK == 4'h0 && VEC_RANK == 4'h0)
    else $error("reset not at highest rank");
  a_base_drop: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ3
    q.st == epm_pkg::ST_RESET && CORE_EV.first_insn
      |=> ACT_RANK == 4'hb && q.st == epm_pkg::ST_RUN)
    else $error("reset did not drop to base level");
  a_nmi_soft: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ5
    $rose(q.pend[2]) |-> $past(wr) && $past(PADDR) == epm_pkg::OFF_CTRL)
    else $error("nmi pended without software write");
  a_bus_escal: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ6
    q.st == epm_pkg::ST_RUN && CORE_EV.bus_fault && !q.bus_en
      |=> q.pend[3] && !$rose(q.pend[5]))
    else $error("disabled bus fault did not escalate");
  a_dbg_gate: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ12
    $rose(q.pend[12]) |-> $past(q.dbg_en) && !$past(CORE_EV.halting) &&
      $past(rk_dbg) < $past(q.act_rank))
    else $error("debug monitor pended while gated");
  a_resv_quiet: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ21
    (q.pend[epm_pkg::VN-1:epm_pkg::V_IRQ0] & ~epm_pkg::IRQ_MASK) == 32'h0)
    else $error("reserved line pended");
  a_win_rank: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ22
    VEC_VALID && q.st == epm_pkg::ST_RUN |-> VEC_RANK < ACT_RANK &&
      q.pend[VEC_NUM] && VEC_RANK >= 4'h1)
    else $error("presented vector does not outrank activation");
  a_irq_lat: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ15
    q.st == epm_pkg::ST_RUN && q.irq_s2[0] && q.irq_en[0] && !CORE_EV.ack
      |=> q.pend[16])
    else $error("enabled line 0 not pended");
  a_mem_route: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ7
    q.st == epm_pkg::ST_RUN && CORE_EV.mem_fault && rk_mem < q.act_rank
      |=> q.pend[epm_pkg::V_MEM])
    else $error("memory fault not pended at its vector");
  a_usage_escal: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ6
    q.st == epm_pkg::ST_RUN && CORE_EV.usage_fault && rk_usage >= q.act_rank
      |=> q.pend[epm_pkg::V_HARD])
    else $error("blocked usage fault did not escalate");
  a_svc_pend: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ11
    q.st == epm_pkg::ST_RUN && CORE_EV.svc_exec
      |=> q.pend[epm_pkg::V_SVC])
    else $error("service call not pended");
  a_tick_pend: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ14
    q.st == epm_pkg::ST_RUN && CORE_EV.tick_expire
      |=> q.pend[epm_pkg::V_TICK])
    else $error("tick expiry not pended");
  a_pendable_service_request_soft: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ13
    $rose(q.pend[epm_pkg::V_PENDABLE_SERVICE_REQUEST]) |->
      $past(wr) && $past(PADDR) == epm_pkg::OFF_CTRL)
    else $error("pendable service pended without software write");
  a_prio_reset: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ16
    q.st == epm_pkg::ST_SP && !SYS_RST |-> q.pri == '0)
    else $error("settable priorities not cleared by reset");
  a_ack_take: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ22
    q.st == epm_pkg::ST_RUN && CORE_EV.ack && VEC_VALID
      |=> ACT_VEC == $past(VEC_NUM) && ACT_RANK == $past(VEC_RANK))
    else $error("taken vector not made the activation");
  a_nmi_rank: assert property (@(posedge CLK) disable iff (SYS_RST) // RQ4
    VEC_VALID && VEC_NUM == epm_pkg::V_NMI |-> VEC_RANK == epm_pkg::RK_NMI)
    else $error("nmi presented at wrong rank");
endmodule
`default_nettype wire

// ==== testbench/epm_core_model.sv ====
// core model: takes presented vectors after a lag
`timescale 1ns/100ps
`default_nettype none
module epm_core_model (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // bench side
  input  wire logic                  take,
  input  wire logic [3:0]            lag,
  input  wire epm_pkg::epm_core_ev_t cmd,
  // design side
  input  wire logic                  vec_valid,
  output var  epm_pkg::epm_core_ev_t core_ev
);
  logic [3:0] wait_ff;
  logic       ack_ff;
  logic       go;
  assign go = take && vec_valid && !ack_ff;
  // one ack pulse once the vector stood lag cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 4'h0;
      ack_ff  <= 1'b0;
    end else begin
      ack_ff  <= go && wait_ff >= lag;
      wait_ff <= (go && wait_ff < lag) ? wait_ff + 4'h1 : 4'h0;
    end
  end
  always_comb begin
    core_ev     = cmd;
    core_ev.ack = cmd.ack | ack_ff;
  end
endmodule
`default_nettype wire

// ==== testbench/exception_priority_map_bench.sv ====
// self-checking bench for the exception priority map
`timescale 1ns/100ps
`default_nettype none
module exception_priority_map_bench;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [9:0]  ev;
    logic [5:0]  vec;
    logic [3:0]  rank;
  } epm_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, take = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h0, irq = 32'h0, prd, q;
  logic [3:0]  lag = 4'h0, vr, ar;
  logic [5:0]  vn, av;
  logic        prdy, perr, e, spl, vv;
  int          fail_count = 0, samples_checked = 0, cycles = 0;
  logic [5:0]  iv [3] = '{6'h11, 6'h12, 6'h10};
  logic [3:0]  ir [3] = '{4'h3, 4'h3, 4'h6};
  epm_pkg::epm_core_ev_t cmd = '0, ev;
  epm_row_t    rows [10] = '{
    '{32'h4, 10'h020, 6'h0b, 4'h3},
    '{32'h4, 10'h100, 6'h04, 4'h3},
    '{32'h4, 10'h040, 6'h06, 4'h3},
    '{32'h4, 10'h004, 6'h0f, 4'h3},
    '{32'h4, 10'h080, 6'h05, 4'h3},
    '{32'h6, 10'h000, 6'h0e, 4'h3},
    '{32'h5, 10'h000, 6'h02, 4'h1},
    '{32'hc, 10'h010, 6'h0c, 4'h3},
    '{32'h0, 10'h080, 6'h03, 4'h2},
    '{32'h4, 10'h140, 6'h04, 4'h3}
  };
  always #25 clk = ~clk;
  epm_exception_map uut (
    .CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .CORE_EV(ev), .IRQ(irq),
    .SP_LOAD(spl), .VEC_VALID(vv), .VEC_NUM(vn), .VEC_RANK(vr),
    .ACT_VEC(av), .ACT_RANK(ar)
  );
  epm_core_model core (
    .clk(clk), .rst(rst), .take(take), .lag(lag), .cmd(cmd),
    .vec_valid(vv), .core_ev(ev)
  );
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    r = prd;
    err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic pulse(input logic [9:0] x);
    @(posedge clk);
    cmd <= x;
    @(posedge clk);
    cmd <= '0;
  endtask
  task automatic wait_vec();
    int n;
    n = 0;
    @(negedge clk);
    while (vv !== 1'b1 && n < 8) begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic serve(input logic [5:0] v);
    int n;
    n = 0;
    @(posedge clk);
    take <= 1'b1;
    while (av !== v && n < 12) begin
      n++;
      @(negedge clk);
    end
    chk(av, v);
    @(posedge clk);
    take <= 1'b0;
    pulse(10'h001);
    @(negedge clk);
    chk(ar, epm_pkg::RK_BASE);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk({spl, vv, ar}, {2'b10, epm_pkg::RK_RESET});
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({spl, vv, vn, vr}, {2'b01, epm_pkg::V_RESET, 4'h0});
    for (int a = 4; a < 28; a += 4) begin
      apb(1'b0, 8'(a), 32'h0, q, e);
      chk(q, 32'h0);
    end
    pulse(10'h200);
    repeat (2) @(negedge clk);
    chk(ar, epm_pkg::RK_BASE);
    apb(1'b0, epm_pkg::OFF_STATUS, 32'h0, q, e);
    chk(q, 32'h00ac0b00);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, epm_pkg::OFF_CTRL, rows[i].ctrl, q, e);
      lag <= 4'(3 * (i % 2));
      pulse(rows[i].ev);
      wait_vec();
      chk({vn, vr}, {rows[i].vec, rows[i].rank});
      serve(rows[i].vec);
    end
    wait_vec();
    chk({vn, vr}, {6'h06, 4'h3});
    serve(6'h06);
    apb(1'b1, epm_pkg::OFF_PRI_SY, 32'h01002007, q, e);
    apb(1'b0, epm_pkg::OFF_PRI_SY, 32'h0, q, e);
    chk(q, 32'h01002007);
    pulse(10'h024);
    wait_vec();
    chk({vn, vr}, {6'h0f, 4'h4});
    serve(6'h0f);
    wait_vec();
    chk({vn, vr}, {6'h0b, 4'h5});
    serve(6'h0b);
    apb(1'b1, epm_pkg::OFF_IRQ_EN, 32'hffffffff, q, e);
    apb(1'b0, epm_pkg::OFF_IRQ_EN, 32'h0, q, e);
    chk(q, 32'h3ffc01ff);
    apb(1'b1, epm_pkg::OFF_PRI_IR, 32'h3, q, e);
    irq <= 32'h207;
    wait_vec();
    apb(1'b0, epm_pkg::OFF_PEND, 32'h0, q, e);
    chk(q, 32'h7);
    irq <= 32'h0;
    for (int k = 0; k < 3; k++) begin
      wait_vec();
      chk({vn, vr}, {iv[k], ir[k]});
      serve(iv[k]);
    end
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, epm_pkg::OFF_CTRL, k ? 32'h8 : 32'h0, q, e);
      pulse(k ? 10'h018 : 10'h010);
      repeat (3) @(negedge clk);
      chk(vv, 1'b0);
    end
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk(e, 32'h1);
    chk(q, 32'h0);
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk({spl, vv}, 2'b10);
    give_verdict();
  end
endmodule
`default_nettype wire
